// file: shared/fdp_pkg.sv
// What this block does
// - debug enabled on fresh or reprogrammed device
// - only firmware may disable debug
// - reenable needs erase, unprotect, enabling firmware
// - device security blocks all external interfaces forever
// - protection level starts open
// - open may move to protected
// - protected level refuses debug accesses
// - protected returns open only after full erase
// - open may move to kill
// - kill rejects every debug access
// - kill refuses external erase requests
// - kill level is terminal
// - per-row read and write protection
// - system calls reach flash at every level once stored settings are restored
package fdp_pkg;
    // ----------------------------------------
    // protection levels and sizes
    // ----------------------------------------
    typedef enum logic [1:0] {
        FDP_OPEN,
        FDP_PROTECTED,
        FDP_KILL
    } fdp_level_t;

    localparam int FDP_ROWS = 128;
    localparam int FDP_ROW_W = 7;
    localparam logic FDP_DBG_EN_RESET = 1'h1;
    localparam logic FDP_ERASED_RESET = 1'h0;
    localparam logic FDP_SECURE_RESET = 1'h0;
    localparam logic FDP_READY_RESET = 1'h0;
endpackage

// file: design/fdp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module fdp_ctrl
    import fdp_pkg::*;
(
    input wire logic mclk_in, // system clock
    input wire logic resetn_in, // sync reset, active low
    input wire fdp_level_t nv_level_in, // stored protection level
    input wire logic nv_dbg_en_in, // stored debug enable
    input wire logic nv_secure_in, // stored device security
    input wire logic nv_valid_in, // nonvolatile values are ready
    input wire logic fw_dbg_dis_in, // firmware disables debug
    input wire logic fw_dbg_en_in, // firmware (new image) enables debug
    input wire logic fw_secure_in, // firmware sets device security
    input wire logic lvl_req_in, // level change request pulse
    input wire fdp_level_t lvl_target_in, // requested level
    input wire logic full_erase_done_in, // full flash erase completed
    input wire logic ext_erase_req_in, // erase request from probe
    input wire logic dbg_req_in, // probe access request
    input wire logic row_cfg_we_in, // row protection write (firmware)
    input wire logic [FDP_ROW_W-1:0] row_cfg_row_in, // row to configure
    input wire logic row_cfg_rd_blk_in, // block reads of row
    input wire logic row_cfg_wr_blk_in, // block writes of row
    input wire logic flash_rd_in, // external flash read request
    input wire logic flash_wr_in, // external flash write request
    input wire logic [FDP_ROW_W-1:0] flash_row_in, // row accessed
    input wire logic syscall_req_in, // internal system-call flash op
    output logic dbg_grant_out, // probe access granted
    output logic dbg_refuse_out, // probe access refused
    output logic ext_erase_ok_out, // external erase allowed
    output logic flash_ok_out, // flash access allowed
    output logic syscall_ok_out, // system-call op allowed
    output fdp_level_t level_out, // current protection level
    output logic dbg_en_out, // debug enable state
    output logic secure_out, // device security set
    output logic ready_out // settings restored
);
    // ----------------------------------------
    // protection state
    // ----------------------------------------
    fdp_level_t level, next_level;
    logic dbg_en, next_dbg_en;
    logic secure, next_secure;
    logic ready, next_ready;
    logic erased, next_erased;
    logic [FDP_ROWS-1:0] rd_blk, next_rd_blk;
    logic [FDP_ROWS-1:0] wr_blk, next_wr_blk;
    logic dbg_allowed;

    always_comb begin
        next_level = level;
        next_dbg_en = dbg_en;
        next_secure = secure;
        next_ready = ready;
        next_erased = erased;
        if (!ready) begin
            if (nv_valid_in) begin
                next_level = nv_level_in;
                next_dbg_en = nv_dbg_en_in;
                next_secure = nv_secure_in;
                next_ready = 1'h1;
            end
        end else begin
            // firmware is the only source of a disable; probe has no path here
            if (fw_dbg_dis_in) begin
                next_dbg_en = 1'h0;
            end else if (fw_dbg_en_in && !dbg_en && erased && level == FDP_OPEN) begin
                next_dbg_en = 1'h1;
            end
            if (fw_secure_in) begin
                next_secure = 1'h1;
            end
            if (full_erase_done_in) begin
                next_erased = 1'h1;
            end
            if (lvl_req_in) begin
                case (level)
                    FDP_OPEN: begin
                        if (lvl_target_in == FDP_PROTECTED) begin
                            next_level = FDP_PROTECTED;
                            // an erase finishing in the same cycle still counts: set wins
                            next_erased = full_erase_done_in;
                        end else if (lvl_target_in == FDP_KILL) begin
                            next_level = FDP_KILL;
                        end
                    end
                    FDP_PROTECTED: begin
                        if (lvl_target_in == FDP_OPEN && (erased || full_erase_done_in)) begin
                            next_level = FDP_OPEN;
                        end
                    end
                    FDP_KILL: begin
                        next_level = FDP_KILL;
                    end
                    default: begin
                        next_level = level;
                    end
                endcase
            end
        end
    end

    always_comb begin
        next_rd_blk = rd_blk;
        next_wr_blk = wr_blk;
        if (row_cfg_we_in) begin
            next_rd_blk[row_cfg_row_in] = row_cfg_rd_blk_in;
            next_wr_blk[row_cfg_row_in] = row_cfg_wr_blk_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            level <= FDP_OPEN;
            dbg_en <= FDP_DBG_EN_RESET;
            secure <= FDP_SECURE_RESET;
            ready <= FDP_READY_RESET;
            erased <= FDP_ERASED_RESET;
            rd_blk <= '0;
            wr_blk <= '0;
        end else begin
            level <= next_level;
            dbg_en <= next_dbg_en;
            secure <= next_secure;
            ready <= next_ready;
            erased <= next_erased;
            rd_blk <= next_rd_blk;
            wr_blk <= next_wr_blk;
        end
    end

    // ----------------------------------------
    // access gating
    // ----------------------------------------
    // every probe request is refused until stored settings are in
    assign dbg_allowed = ready && dbg_en && !secure && level == FDP_OPEN;

    logic next_grant, next_refuse, next_erase_ok, next_flash_ok, next_sys_ok;
    always_comb begin
        next_grant = dbg_req_in && dbg_allowed;
        next_refuse = dbg_req_in && !dbg_allowed;
        next_erase_ok = ext_erase_req_in && dbg_allowed;
        next_flash_ok = dbg_allowed && ((flash_rd_in && !rd_blk[flash_row_in]) ||
                        (flash_wr_in && !wr_blk[flash_row_in]));
        next_sys_ok = syscall_req_in && ready;
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            dbg_grant_out <= 1'h0;
            dbg_refuse_out <= 1'h0;
            ext_erase_ok_out <= 1'h0;
            flash_ok_out <= 1'h0;
            syscall_ok_out <= 1'h0;
        end else begin
            dbg_grant_out <= next_grant;
            dbg_refuse_out <= next_refuse;
            ext_erase_ok_out <= next_erase_ok;
            flash_ok_out <= next_flash_ok;
            syscall_ok_out <= next_sys_ok;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            level_out <= FDP_OPEN;
            dbg_en_out <= FDP_DBG_EN_RESET;
            secure_out <= FDP_SECURE_RESET;
            ready_out <= FDP_READY_RESET;
        end else begin
            level_out <= next_level;
            dbg_en_out <= next_dbg_en;
            secure_out <= next_secure;
            ready_out <= next_ready;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_kill_terminal;
        @(posedge mclk_in) disable iff (!resetn_in)
        (level == FDP_KILL) |=> (level == FDP_KILL);
    endproperty
    a_kill_terminal: assert property (p_kill_terminal) else $error("kill level left");

    property p_kill_no_dbg;
        @(posedge mclk_in) disable iff (!resetn_in)
        (dbg_req_in && level == FDP_KILL) |=> (!dbg_grant_out && dbg_refuse_out);
    endproperty
    a_kill_no_dbg: assert property (p_kill_no_dbg) else $error("debug granted in kill");

    property p_prot_no_dbg;
        @(posedge mclk_in) disable iff (!resetn_in)
        (dbg_req_in && level == FDP_PROTECTED) |=> dbg_refuse_out;
    endproperty
    a_prot_no_dbg: assert property (p_prot_no_dbg) else $error("debug granted when protected");

    property p_kill_no_erase;
        @(posedge mclk_in) disable iff (!resetn_in)
        (level == FDP_KILL) |=> !ext_erase_ok_out;
    endproperty
    a_kill_no_erase: assert property (p_kill_no_erase) else $error("external erase in kill");

    property p_secure_sticky;
        @(posedge mclk_in) disable iff (!resetn_in)
        secure |=> (secure && !dbg_grant_out && !ext_erase_ok_out);
    endproperty
    a_secure_sticky: assert property (p_secure_sticky) else $error("security reopened");

    property p_open_needs_erase;
        @(posedge mclk_in) disable iff (!resetn_in)
        ($past(level) == FDP_PROTECTED && level == FDP_OPEN) |-> ($past(erased) || $past(full_erase_done_in));
    endproperty
    a_open_needs_erase: assert property (p_open_needs_erase) else $error("unprotect without erase");

    property p_dis_only_fw;
        @(posedge mclk_in) disable iff (!resetn_in)
        (ready && dbg_en && !fw_dbg_dis_in) |=> dbg_en;
    endproperty
    a_dis_only_fw: assert property (p_dis_only_fw) else $error("debug disabled without firmware");

    property p_syscall;
        @(posedge mclk_in) disable iff (!resetn_in)
        (syscall_req_in && ready) |=> syscall_ok_out;
    endproperty
    a_syscall: assert property (p_syscall) else $error("system call refused");

    property p_open_to_prot;
        @(posedge mclk_in) disable iff (!resetn_in)
        (ready && level == FDP_OPEN && lvl_req_in && lvl_target_in == FDP_PROTECTED) |=> (level == FDP_PROTECTED);
    endproperty
    a_open_to_prot: assert property (p_open_to_prot) else $error("open to protected refused");

    property p_restore_first;
        @(posedge mclk_in) disable iff (!resetn_in)
        !ready |=> !dbg_grant_out;
    endproperty
    a_restore_first: assert property (p_restore_first) else $error("debug before restore");
endmodule
`default_nettype wire

// file: tb/fdp_probe.sv
`timescale 1ns/10ps
`default_nettype none
module fdp_probe
    import fdp_pkg::*;
(
    input wire logic mclk_in, // system clock
    output logic dbg_req_out, // probe access request
    output logic erase_req_out, // probe erase request
    output logic rd_out, // probe flash read
    output logic wr_out, // probe flash write
    output logic [FDP_ROW_W-1:0] row_out // row accessed
);
    initial begin
        {dbg_req_out, erase_req_out, rd_out, wr_out} = 4'h0;
        row_out = 7'h00;
    end

    // ----------------------------------------
    // one access: kind 0 debug, 1 read, 2 write, 3 erase
    // ----------------------------------------
    task automatic access(input logic [1:0] kind, input logic [FDP_ROW_W-1:0] row, input int idle);
        repeat (idle) @(posedge mclk_in);
        @(posedge mclk_in);
        #1;
        dbg_req_out = 1'h1;
        erase_req_out = (kind == 2'h3);
        rd_out = (kind == 2'h1);
        wr_out = (kind == 2'h2);
        row_out = row;
        @(posedge mclk_in);
        #1;
        {dbg_req_out, erase_req_out, rd_out, wr_out} = 4'h0;
        // released row must not keep a stale copy
        row_out = ~row;
    endtask
endmodule
`default_nettype wire

// file: tb/test_flash_debug_protection_control.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_flash_debug_protection_control
    import fdp_pkg::*;
;
    logic mclk_in = 1'h0, resetn_in = 1'h0, nv_dbg_en_in = 1'h1, nv_secure_in = 1'h0, nv_valid_in = 1'h1;
    logic fw_dbg_dis_in = 1'h0, fw_dbg_en_in = 1'h0, fw_secure_in = 1'h0, syscall_req_in = 1'h0;
    logic lvl_req_in = 1'h0, full_erase_done_in = 1'h0, row_cfg_we_in = 1'h0;
    logic row_cfg_rd_blk_in = 1'h0, row_cfg_wr_blk_in = 1'h0;
    logic [FDP_ROW_W-1:0] row_cfg_row_in = 7'h00, flash_row_in;
    fdp_level_t nv_level_in = FDP_OPEN, lvl_target_in = FDP_OPEN, level_out;
    logic dbg_req_in, ext_erase_req_in, flash_rd_in, flash_wr_in, dbg_grant_out, dbg_refuse_out;
    logic ext_erase_ok_out, flash_ok_out, syscall_ok_out, dbg_en_out, secure_out, ready_out;
    int err_total = 0, tests_run = 0;

    always #50 mclk_in = ~mclk_in;

    fdp_probe probe (.mclk_in(mclk_in), .dbg_req_out(dbg_req_in), .erase_req_out(ext_erase_req_in),
        .rd_out(flash_rd_in), .wr_out(flash_wr_in), .row_out(flash_row_in));

    fdp_ctrl DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .nv_level_in(nv_level_in),
        .nv_dbg_en_in(nv_dbg_en_in), .nv_secure_in(nv_secure_in), .nv_valid_in(nv_valid_in),
        .fw_dbg_dis_in(fw_dbg_dis_in), .fw_dbg_en_in(fw_dbg_en_in), .fw_secure_in(fw_secure_in),
        .lvl_req_in(lvl_req_in), .lvl_target_in(lvl_target_in), .full_erase_done_in(full_erase_done_in),
        .ext_erase_req_in(ext_erase_req_in), .dbg_req_in(dbg_req_in), .row_cfg_we_in(row_cfg_we_in),
        .row_cfg_row_in(row_cfg_row_in), .row_cfg_rd_blk_in(row_cfg_rd_blk_in),
        .row_cfg_wr_blk_in(row_cfg_wr_blk_in), .flash_rd_in(flash_rd_in), .flash_wr_in(flash_wr_in),
        .flash_row_in(flash_row_in), .syscall_req_in(syscall_req_in), .dbg_grant_out(dbg_grant_out),
        .dbg_refuse_out(dbg_refuse_out), .ext_erase_ok_out(ext_erase_ok_out), .flash_ok_out(flash_ok_out),
        .syscall_ok_out(syscall_ok_out), .level_out(level_out), .dbg_en_out(dbg_en_out),
        .secure_out(secure_out), .ready_out(ready_out));

    task tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task tick; @(posedge mclk_in); #1; endtask
    task do_reset(input fdp_level_t lv);
        nv_level_in = lv;
        resetn_in = 1'h0;
        repeat (12) tick;
        resetn_in = 1'h1;
        for (int i = 0; i < 5 && ready_out !== 1'h1; i++) tick;
        `CHK("ready", 1'h1, ready_out)
        tick;
    endtask
    task lvl(input fdp_level_t t); tick; lvl_req_in = 1'h1; lvl_target_in = t; tick; lvl_req_in = 1'h0; endtask
    task erase; tick; full_erase_done_in = 1'h1; tick; full_erase_done_in = 1'h0; endtask
    // 0 disable debug, 1 enable debug, 2 security, 3 system call
    task fw(input int s);
        tick;
        case (s)
            0: fw_dbg_dis_in = 1'h1;
            1: fw_dbg_en_in = 1'h1;
            2: fw_secure_in = 1'h1;
            default: syscall_req_in = 1'h1;
        endcase
        tick;
        {fw_dbg_dis_in, fw_dbg_en_in, fw_secure_in, syscall_req_in} = 4'h0;
    endtask
    task row_cfg(input logic [FDP_ROW_W-1:0] r, input logic rb, input logic wb);
        tick;
        {row_cfg_we_in, row_cfg_row_in, row_cfg_rd_blk_in, row_cfg_wr_blk_in} = {1'h1, r, rb, wb};
        tick;
        row_cfg_we_in = 1'h0;
    endtask
    task pchk(input logic [1:0] k, input logic [FDP_ROW_W-1:0] r, input logic g, input int idle);
        probe.access(k, r, idle);
        case (k)
            2'h0: begin `CHK("grant", g, dbg_grant_out) `CHK("refuse", ~g, dbg_refuse_out) end
            2'h3: `CHK("erase_ok", g, ext_erase_ok_out)
            default: `CHK("flash_ok", g, flash_ok_out)
        endcase
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task s_open;
        `CHK("level", FDP_OPEN, level_out)
        pchk(2'h0, 7'h00, 1'h1, 2);
        row_cfg(7'h7F, 1'h0, 1'h1);
        pchk(2'h2, 7'h7F, 1'h0, 0);
        pchk(2'h1, 7'h7F, 1'h1, 0);
        pchk(2'h2, 7'h7E, 1'h1, 0);
        row_cfg(7'h00, 1'h1, 1'h0);
        pchk(2'h1, 7'h00, 1'h0, 0);
        pchk(2'h3, 7'h05, 1'h1, 0);
        `CHK("dbg_en", 1'h1, dbg_en_out)
    endtask
    task s_dbgdis;
        fw(0);
        pchk(2'h0, 7'h01, 1'h0, 0);
        fw(1);
        `CHK("dbg_en", 1'h0, dbg_en_out)
        erase;
        fw(1);
        pchk(2'h0, 7'h01, 1'h1, 0);
    endtask
    task s_protect;
        lvl(FDP_PROTECTED);
        `CHK("level", FDP_PROTECTED, level_out)
        pchk(2'h0, 7'h02, 1'h0, 0);
        fw(3);
        `CHK("syscall", 1'h1, syscall_ok_out)
        lvl(FDP_KILL);
        `CHK("level", FDP_PROTECTED, level_out)
        lvl(FDP_OPEN);
        `CHK("level", FDP_PROTECTED, level_out)
        erase;
        lvl(FDP_OPEN);
        `CHK("level", FDP_OPEN, level_out)
    endtask
    task s_kill;
        lvl(FDP_KILL);
        `CHK("level", FDP_KILL, level_out)
        pchk(2'h0, 7'h03, 1'h0, 0);
        pchk(2'h1, 7'h03, 1'h0, 0);
        pchk(2'h3, 7'h03, 1'h0, 0);
        erase;
        lvl(FDP_OPEN);
        `CHK("level", FDP_KILL, level_out)
        fw(3);
        `CHK("syscall", 1'h1, syscall_ok_out)
    endtask
    // stored settings late, and a stored debug disable
    task s_restore;
        nv_valid_in = 1'h0;
        nv_dbg_en_in = 1'h0;
        resetn_in = 1'h0;
        repeat (12) tick;
        resetn_in = 1'h1;
        pchk(2'h0, 7'h06, 1'h0, 0);
        `CHK("ready", 1'h0, ready_out)
        nv_valid_in = 1'h1;
        tick;
        `CHK("ready", 1'h1, ready_out)
        `CHK("dbg_en", 1'h0, dbg_en_out)
        pchk(2'h0, 7'h06, 1'h0, 0);
        nv_dbg_en_in = 1'h1;
    endtask
    task s_secure;
        do_reset(FDP_PROTECTED);
        pchk(2'h0, 7'h04, 1'h0, 0);
        do_reset(FDP_OPEN);
        fw(2);
        `CHK("secure", 1'h1, secure_out)
        erase;
        fw(1);
        pchk(2'h0, 7'h04, 1'h0, 0);
        pchk(2'h3, 7'h04, 1'h0, 0);
        // stored security must come back after a reset
        nv_secure_in = 1'h1;
        do_reset(FDP_OPEN);
        `CHK("secure", 1'h1, secure_out)
        pchk(2'h0, 7'h04, 1'h0, 0);
    endtask

    initial begin
        do_reset(FDP_OPEN);
        s_open;
        s_dbgdis;
        s_protect;
        s_kill;
        s_restore;
        s_secure;
        tally_and_finish;
    end
    // run needs well under 300 cycles
    initial begin
        repeat (3000) @(posedge mclk_in);
        err_total++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
